// *** logic/gdp_pkg.sv ***
// Shared constants for the four data registers of three general-purpose ports
package gdp_pkg;

  // ----------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------
  localparam int          AXI_AW        = 8;
  localparam int          AXI_DW        = 32;
  localparam int          REG_W         = 16;
  localparam int          BYTE_W        = 8;

  // ----------------------------------------------------------------
  // Port widths (data bits per register; PC_W is the whole third port)
  // ----------------------------------------------------------------
  localparam int          PA_W          = 10;
  localparam int          PB_W          = 14;
  localparam int          PC_HI_W       = 5;
  localparam int          PC_LO_W       = 16;
  localparam int          PC_W          = 21;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_PA_DATA   = 8'h00;
  localparam logic [7:0]  OFS_PB_DATA   = 8'h04;
  localparam logic [7:0]  OFS_PC_DATA_H = 8'h08;
  localparam logic [7:0]  OFS_PC_DATA_L = 8'h0c;
  localparam logic [7:0]  OFS_PA_DRIVE  = 8'h10;
  localparam logic [7:0]  OFS_PB_DRIVE  = 8'h14;
  localparam logic [7:0]  OFS_PC_DRV_H  = 8'h18;
  localparam logic [7:0]  OFS_PC_DRV_L  = 8'h1c;

  // ----------------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RESET    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Channel states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    GDP_WS_IDLE = 1'b0,
    GDP_WS_RESP = 1'b1
  } gdp_wstate_t;

  typedef enum logic [0:0] {
    GDP_RS_IDLE = 1'b0,
    GDP_RS_DATA = 1'b1
  } gdp_rstate_t;

endpackage

// *** logic/gdp_port_bits.sv ***
// One port data register slice: storage, pin drive and read-back select
`timescale 1ns/1ps
module gdp_port_bits
  import gdp_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_bit_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] alt_sel,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] rd_val,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] data_reg;
  logic [W-1:0] data_next;
  logic [W-1:0] gen_out;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Writes always land in storage, whatever the pin mode
  always_comb begin
    data_next = data_reg;
    if (wr_en) begin
      data_next = (data_reg & ~wr_bit_en) | (wr_data & wr_bit_en); // R4 R7 R8
    end
  end

  // Every data bit clears on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= W'(DATA_RESET); // R10
    end else begin
      data_reg <= data_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and read-back
  // ----------------------------------------------------------------
  // Only a port-function output pin is driven from storage
  assign gen_out = dir & ~alt_sel; // R11
  assign pin_out = data_reg; // R5
  assign pin_oe  = gen_out; // R5 R7 R8

  // Port-function input reads the pin, all else reads storage
  assign rd_val  = (dir | alt_sel) == {W{1'b1}} ? data_reg :
                   ((pin_in & ~dir & ~alt_sel) | (data_reg & (dir | alt_sel))); // R5 R6 R8

endmodule

// *** logic/gdp_ports.sv ***
// Data registers for three general-purpose ports behind an AXI4-Lite slave
//
// What this block does
// R1: First port has ten pins at bits 9..0; bits 15..10 reserved.
// R2: Second port has fourteen pins at bits 13..0; bits 15..14 reserved.
// R3: Third port: pins 20..16 in high bits 4..0, pins 15..0 in low.
// R4: Each port data register is 16 bits, software readable and writable.
// R5: Output pin drives the written value; read returns stored bit.
// R6: Input pin read returns the live pin level, not storage.
// R7: Input pin writes update storage but leave the pin alone.
// R8: Alternate-function pin reads storage; writes update storage only.
// R9: Reserved bits read zero; software writes only zero to them.
// R10: Every implemented data bit resets to zero.
// R11: Direction and function select arrive per pin from outside.
`timescale 1ns/1ps
module gdp_ports
  import gdp_pkg::*;
(
  input  wire logic                SYS_CLK,
  input  wire logic                RESET,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0]   S_AXI_AWADDR,
  input  wire logic [2:0]          S_AXI_AWPROT,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [AXI_DW-1:0]   S_AXI_WDATA,
  input  wire logic [AXI_DW/8-1:0] S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0]   S_AXI_ARADDR,
  input  wire logic [2:0]          S_AXI_ARPROT,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [AXI_DW-1:0]        S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  // First port pins and per-pin selection
  input  wire logic [PA_W-1:0]     PA_PIN_IN,
  output logic      [PA_W-1:0]     PA_PIN_OUT,
  output logic      [PA_W-1:0]     PA_PIN_OE,
  input  wire logic [PA_W-1:0]     PA_DIR,
  input  wire logic [PA_W-1:0]     PA_ALT_SEL,
  // Second port pins and per-pin selection
  input  wire logic [PB_W-1:0]     PB_PIN_IN,
  output logic      [PB_W-1:0]     PB_PIN_OUT,
  output logic      [PB_W-1:0]     PB_PIN_OE,
  input  wire logic [PB_W-1:0]     PB_DIR,
  input  wire logic [PB_W-1:0]     PB_ALT_SEL,
  // Third port pins and per-pin selection
  input  wire logic [PC_W-1:0]     PC_PIN_IN,
  output logic      [PC_W-1:0]     PC_PIN_OUT,
  output logic      [PC_W-1:0]     PC_PIN_OE,
  input  wire logic [PC_W-1:0]     PC_DIR,
  input  wire logic [PC_W-1:0]     PC_ALT_SEL
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gdp_wstate_t        wstate_reg;
  gdp_rstate_t        rstate_reg;

  logic               aw_held_reg;
  logic               w_held_reg;
  logic [AXI_AW-1:0]  awaddr_reg;
  logic [REG_W-1:0]   wdata_reg;
  logic [1:0]         wstrb_reg;
  logic [1:0]         bresp_reg;
  logic [AXI_DW-1:0]  rdata_reg;
  logic [1:0]         rresp_reg;

  // Handshake qualifiers and write strobes
  logic               aw_take;
  logic               w_take;
  logic               ar_take;
  logic               do_write;
  logic [REG_W-1:0]   strb_bits;

  // Write register selects
  logic               sel_pa;
  logic               sel_pb;
  logic               sel_pch;
  logic               sel_pcl;
  logic               wr_hit;

  logic [REG_W-1:0]   rd_word;
  logic               rd_hit;
  logic [REG_W-1:0]   pa_word;
  logic [REG_W-1:0]   pb_word;
  logic [REG_W-1:0]   pch_word;
  logic [REG_W-1:0]   pcl_word;

  // Per-port read-back values and third-port halves
  logic [PA_W-1:0]    pa_rd;
  logic [PB_W-1:0]    pb_rd;
  logic [PC_HI_W-1:0] pch_rd;
  logic [PC_LO_W-1:0] pcl_rd;
  logic [PC_HI_W-1:0] pch_oe;
  logic [PC_LO_W-1:0] pcl_oe;
  logic [PC_HI_W-1:0] pch_out;
  logic [PC_LO_W-1:0] pcl_out;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  // Address and data are taken independently, one of each per write
  assign S_AXI_AWREADY = (wstate_reg == GDP_WS_IDLE) && !aw_held_reg;
  assign S_AXI_WREADY  = (wstate_reg == GDP_WS_IDLE) && !w_held_reg;
  assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take        = S_AXI_WVALID && S_AXI_WREADY;
  assign do_write      = (wstate_reg == GDP_WS_IDLE) && aw_held_reg && w_held_reg;

  // Latch the write address once taken
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Latch the low half of the write data and its strobes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= S_AXI_WDATA[REG_W-1:0];
      wstrb_reg  <= S_AXI_WSTRB[1:0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Byte strobes widen into per-bit enables
  assign strb_bits = {{BYTE_W{wstrb_reg[1]}}, {BYTE_W{wstrb_reg[0]}}};

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Only the four data registers accept writes
  always_comb begin
    sel_pa  = 1'b0;
    sel_pb  = 1'b0;
    sel_pch = 1'b0;
    sel_pcl = 1'b0;
    case (awaddr_reg)
      OFS_PA_DATA:   sel_pa  = 1'b1;
      OFS_PB_DATA:   sel_pb  = 1'b1;
      OFS_PC_DATA_H: sel_pch = 1'b1;
      OFS_PC_DATA_L: sel_pcl = 1'b1;
      default:       sel_pa  = 1'b0;
    endcase
  end

  // Unmapped and read-only addresses answer with an error
  assign wr_hit = sel_pa || sel_pb || sel_pch || sel_pcl;

  // Response code is fixed on the edge at which the write lands
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Response state: the write lands on the edge that raises BVALID
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wstate_reg <= GDP_WS_IDLE;
    end else begin
      case (wstate_reg)
        GDP_WS_IDLE: begin
          if (do_write) begin
            wstate_reg <= GDP_WS_RESP;
          end
        end
        GDP_WS_RESP: begin
          if (S_AXI_BREADY) begin
            wstate_reg <= GDP_WS_IDLE;
          end
        end
        default: wstate_reg <= GDP_WS_IDLE;
      endcase
    end
  end

  // Write answer stands until the master takes it
  assign S_AXI_BVALID = (wstate_reg == GDP_WS_RESP);
  assign S_AXI_BRESP  = bresp_reg;

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  // First port: upper six bits of the write are never stored
  gdp_port_bits #(.W(PA_W)) u_pa (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .wr_en     (do_write && sel_pa),
    .wr_bit_en (strb_bits[PA_W-1:0]), // R1 R9
    .wr_data   (wdata_reg[PA_W-1:0]),
    .dir       (PA_DIR),
    .alt_sel   (PA_ALT_SEL),
    .pin_in    (PA_PIN_IN),
    .rd_val    (pa_rd),
    .pin_out   (PA_PIN_OUT),
    .pin_oe    (PA_PIN_OE)
  );

  // Second port: top two bits are never stored
  gdp_port_bits #(.W(PB_W)) u_pb (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .wr_en     (do_write && sel_pb),
    .wr_bit_en (strb_bits[PB_W-1:0]), // R2 R9
    .wr_data   (wdata_reg[PB_W-1:0]),
    .dir       (PB_DIR),
    .alt_sel   (PB_ALT_SEL),
    .pin_in    (PB_PIN_IN),
    .rd_val    (pb_rd),
    .pin_out   (PB_PIN_OUT),
    .pin_oe    (PB_PIN_OE)
  );

  // Third port, pins 20..16 in the high register
  gdp_port_bits #(.W(PC_HI_W)) u_pch (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .wr_en     (do_write && sel_pch),
    .wr_bit_en (strb_bits[PC_HI_W-1:0]), // R3 R9
    .wr_data   (wdata_reg[PC_HI_W-1:0]),
    .dir       (PC_DIR[PC_W-1:PC_LO_W]),
    .alt_sel   (PC_ALT_SEL[PC_W-1:PC_LO_W]),
    .pin_in    (PC_PIN_IN[PC_W-1:PC_LO_W]),
    .rd_val    (pch_rd),
    .pin_out   (pch_out),
    .pin_oe    (pch_oe)
  );

  // Third port, pins 15..0 in the low register
  gdp_port_bits #(.W(PC_LO_W)) u_pcl (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .wr_en     (do_write && sel_pcl),
    .wr_bit_en (strb_bits), // R3
    .wr_data   (wdata_reg),
    .dir       (PC_DIR[PC_LO_W-1:0]),
    .alt_sel   (PC_ALT_SEL[PC_LO_W-1:0]),
    .pin_in    (PC_PIN_IN[PC_LO_W-1:0]),
    .rd_val    (pcl_rd),
    .pin_out   (pcl_out),
    .pin_oe    (pcl_oe)
  );

  // Join the two halves of the third port
  assign PC_PIN_OUT = {pch_out, pcl_out}; // R3
  assign PC_PIN_OE  = {pch_oe, pcl_oe};

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Each data register as a full word, reserved bits tied to zero
  assign pa_word  = {{(REG_W-PA_W){1'b0}}, pa_rd}; // R1 R9
  assign pb_word  = {{(REG_W-PB_W){1'b0}}, pb_rd}; // R2 R9
  assign pch_word = {{(REG_W-PC_HI_W){1'b0}}, pch_rd}; // R3 R9
  assign pcl_word = pcl_rd; // R3

  // Address decode; drive views show the enable of each pin
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      OFS_PA_DATA:   rd_word = pa_word; // R1 R9
      OFS_PB_DATA:   rd_word = pb_word; // R2 R9
      OFS_PC_DATA_H: rd_word = pch_word; // R3 R9
      OFS_PC_DATA_L: rd_word = pcl_word; // R3
      OFS_PA_DRIVE:  rd_word = {{(REG_W-PA_W){1'b0}}, PA_PIN_OE};
      OFS_PB_DRIVE:  rd_word = {{(REG_W-PB_W){1'b0}}, PB_PIN_OE};
      OFS_PC_DRV_H:  rd_word = {{(REG_W-PC_HI_W){1'b0}}, pch_oe};
      OFS_PC_DRV_L:  rd_word = pcl_oe;
      default:       rd_hit  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read at a time; data is sampled on the address edge
  assign S_AXI_ARREADY = (rstate_reg == GDP_RS_IDLE);
  assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

  // Read data and status are captured on the edge that takes the address
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rdata_reg <= {{(AXI_DW-REG_W){1'b0}}, rd_word};
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read state: busy from the address edge until the master takes the answer
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rstate_reg <= GDP_RS_IDLE;
    end else begin
      case (rstate_reg)
        GDP_RS_IDLE: begin
          if (ar_take) begin
            rstate_reg <= GDP_RS_DATA;
          end
        end
        GDP_RS_DATA: begin
          if (S_AXI_RREADY) begin
            rstate_reg <= GDP_RS_IDLE;
          end
        end
        default: rstate_reg <= GDP_RS_IDLE;
      endcase
    end
  end

  // Read answer stands until the master takes it
  assign S_AXI_RVALID = (rstate_reg == GDP_RS_DATA);
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

endmodule

// *** dv/gdp_ports_assertions.sv ***
// Assertion checker for the port data register block
`timescale 1ns/1ps
module gdp_ports_chk
  import gdp_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RESET,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic [AXI_DW-1:0] S_AXI_WDATA,
  input wire logic [3:0]        S_AXI_WSTRB,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic              S_AXI_BVALID,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [AXI_DW-1:0] S_AXI_RDATA,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic [PA_W-1:0]   PA_PIN_OUT,
  input wire logic [PA_W-1:0]   PA_PIN_OE,
  input wire logic [PA_W-1:0]   PA_DIR,
  input wire logic [PA_W-1:0]   PA_ALT_SEL,
  input wire logic [PC_W-1:0]   PC_PIN_OE,
  input wire logic [PC_W-1:0]   PC_DIR,
  input wire logic [PC_W-1:0]   PC_ALT_SEL
);
  logic [7:0]  ar_q;
  logic [7:0]  aw_q;
  logic [15:0] wd_q;
  logic [1:0]  ws_q;

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Keeps the fields of the last taken requests
  always_ff @(posedge SYS_CLK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) ar_q <= S_AXI_ARADDR;
    if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
    if (S_AXI_WVALID && S_AXI_WREADY) wd_q <= S_AXI_WDATA[15:0];
    if (S_AXI_WVALID && S_AXI_WREADY) ws_q <= S_AXI_WSTRB[1:0];
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_ar_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence s_wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_pa_land; $rose(S_AXI_BVALID) && aw_q == OFS_PA_DATA && ws_q == 2'h3; endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_oe_port_a: assert property (PA_PIN_OE == (PA_DIR & ~PA_ALT_SEL))
    else $error("first port drive enable wrong");
  a_oe_port_c: assert property (PC_PIN_OE == (PC_DIR & ~PC_ALT_SEL))
    else $error("third port drive enable wrong");
  a_read_turn: assert property (s_ar_take |=> S_AXI_RVALID)
    else $error("read answer late");
  a_read_hold: assert property (!(S_AXI_ARVALID && S_AXI_ARREADY)
    |=> $stable(S_AXI_RDATA) && (S_AXI_RVALID || !$past(S_AXI_RVALID) || $past(S_AXI_RREADY)))
    else $error("read answer dropped");
  a_write_turn: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  a_write_pins: assert property (s_pa_land |-> PA_PIN_OUT == wd_q[9:0])
    else $error("written value not on first port");
  a_pin_hold: assert property (!$rose(S_AXI_BVALID) |-> $stable(PA_PIN_OUT))
    else $error("first port drive moved without write");
  a_resv_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000
    && (ar_q != OFS_PA_DATA || S_AXI_RDATA[15:10] == 6'h00)
    && (ar_q != OFS_PB_DATA || S_AXI_RDATA[15:14] == 2'h0)
    && (ar_q != OFS_PC_DATA_H || S_AXI_RDATA[15:5] == 11'h000))
    else $error("reserved bits read nonzero");
  a_reset_clear: assert property ($fell(RESET) |-> PA_PIN_OUT == '0 && !S_AXI_BVALID)
    else $error("state not cleared by reset");
endmodule

bind gdp_ports gdp_ports_chk u_chk (.*);

// *** dv/gdp_pin_model.sv ***
// Pin-side model: driven pins carry the block's value, released ones an outside level
`timescale 1ns/1ps
module gdp_pin_model #(
  parameter int W = 64
) (
  input  wire logic [W-1:0] drv,
  input  wire logic [W-1:0] drv_en,
  input  wire logic [W-1:0] ext_lvl,
  output logic      [W-1:0] lvl
);
  // Released pins follow the outside level, which the bench changes often
  assign lvl = (drv & drv_en) | (ext_lvl & ~drv_en);
endmodule

// *** dv/test_gdp_ports.sv ***
// Self-checking testbench for the port data register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_gdp_ports
  import gdp_pkg::*;
;
  localparam logic [63:0] MSK = 64'hffff_001f_3fff_03ff;
  logic        clk;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, eb;
  logic [63:0] dsel = '0, asel = '0, xlvl = '0, sh = '0, po, pe, lvl;
  logic [9:0]  pa_out, pa_oe;
  logic [13:0] pb_out, pb_oe;
  logic [20:0] pc_out, pc_oe;
  logic [33:0] er;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, k;

  // ----------------------------------------------------------------
  // Design, pins and clock
  // ----------------------------------------------------------------
  assign po = {pc_out[15:0], 11'h0, pc_out[20:16], 2'h0, pb_out, 6'h0, pa_out};
  assign pe = {pc_oe[15:0], 11'h0, pc_oe[20:16], 2'h0, pb_oe, 6'h0, pa_oe};
  gdp_pin_model #(.W(64)) u_pins (.drv(po), .drv_en(pe), .ext_lvl(xlvl), .lvl(lvl));
  gdp_ports dut (
    .SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PA_PIN_IN(lvl[9:0]), .PA_PIN_OUT(pa_out), .PA_PIN_OE(pa_oe),
    .PA_DIR(dsel[9:0]), .PA_ALT_SEL(asel[9:0]),
    .PB_PIN_IN(lvl[29:16]), .PB_PIN_OUT(pb_out), .PB_PIN_OE(pb_oe),
    .PB_DIR(dsel[29:16]), .PB_ALT_SEL(asel[29:16]),
    .PC_PIN_IN({lvl[36:32], lvl[63:48]}), .PC_PIN_OUT(pc_out), .PC_PIN_OE(pc_oe),
    .PC_DIR({dsel[36:32], dsel[63:48]}), .PC_ALT_SEL({asel[36:32], asel[63:48]})
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and closing
  // ----------------------------------------------------------------
  // Write one register; software keeps reserved bits at zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    exp_b.push_back(a < 8'h10 ? RESP_OKAY : RESP_SLVERR);
    if (a < 8'h10) sh[16 * a[3:2] +: 16] = (sh[16 * a[3:2] +: 16] & ~m) | (d & m);
    awaddr <= a;
    wdata <= {16'($urandom()), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("pins", (sh & dsel & ~asel | xlvl & ~(dsel & ~asel)) & MSK, lvl & MSK)
    @(posedge clk);
  endtask

  // Read one address and note the value it must return
  task automatic rd(input logic [7:0] a);
    logic [63:0] v;
    v = a < 8'h10 ? (sh & (dsel | asel)) | (xlvl & ~(dsel | asel)) : dsel & ~asel;
    v = a < 8'h20 ? v & MSK : '0;
    exp_r.push_back({a < 8'h20 ? RESP_OKAY : RESP_SLVERR, 16'h0, v[16 * a[3:2] +: 16]});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Answers are matched against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) begin
      er = exp_r.pop_front();
      `CHK("read", er, {rresp, rdata})
    end
    if (bvalid && bready) begin
      eb = exp_b.pop_front();
      `CHK("bresp", eb, bresp)
    end
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'he1a2));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    dsel <= '1;
    @(posedge clk);
    for (int i = 0; i < 12; i++) rd(8'(4 * i));
    for (int i = 0; i < 60; i++) begin
      dsel <= {$urandom(), $urandom()};
      asel <= {$urandom(), $urandom()} & {$urandom(), $urandom()};
      xlvl <= {$urandom(), $urandom()};
      k = $urandom() % 4;
      @(posedge clk);
      wr(8'(4 * k), 16'($urandom()) & MSK[16 * k +: 16], 4'($urandom()));
      rd(8'(4 * k));
      rd(8'(4 * ($urandom() % 12)));
    end
    wr(8'h14, 16'h0001, 4'h3);
    wr(8'h30, 16'h0001, 4'h3);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sh = '0;
    dsel <= '1;
    asel <= '0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'(4 * i));
    results();
  end
endmodule
